// ==== rtl/asd_pkg.sv ====
// asd_pkg: address map constants and region/mode enumerations for the address space decoder.
// assumes a 24-bit cpu address; shared by the decoder and the bench.
`default_nettype none
package asd_pkg;
    localparam int ADDR_W = 24;
    // reset fetch address
    localparam logic [23:0] RESET_FETCH_ADDR = 24'hFF2080;
    // page zero and overlay span boundaries
    localparam logic [23:0] CPU_SFR_LO = 24'h000000;
    localparam logic [23:0] CPU_SFR_HI = 24'h000019;
    localparam logic [23:0] LOW_RF_LO = 24'h00001A;
    localparam logic [23:0] LOW_RF_HI = 24'h0000FF;
    localparam logic [23:0] UP_RF_LO = 24'h000100;
    localparam logic [23:0] UP_RF_HI = 24'h0003FF;
    localparam logic [23:0] RAM_LO = 24'h000400;
    localparam logic [23:0] RAM_HI = 24'h000FFF;
    localparam logic [23:0] PER_SFR_LO = 24'h001C00;
    localparam logic [23:0] PER_SFR_HI = 24'h001FDF;
    localparam logic [23:0] MM_SFR_LO = 24'h001FE0;
    localparam logic [23:0] MM_SFR_HI = 24'h001FFF;
    localparam logic [23:0] ROM_COPY_LO = 24'h002400;
    localparam logic [23:0] ROM_COPY_HI = 24'h003FFF;
    localparam logic [23:0] OVERLAY_LO = 24'h1F0000;
    localparam logic [23:0] OVERLAY_HI = 24'hFEFFFF;
    // top page boundaries
    localparam logic [23:0] EMU_LO = 24'hFF0000;
    localparam logic [23:0] EMU_HI = 24'hFF03FF;
    localparam logic [23:0] RAM_ALIAS_LO = 24'hFF0400;
    localparam logic [23:0] RAM_ALIAS_HI = 24'hFF0FFF;
    localparam logic [23:0] CFG_VEC_LO = 24'hFF2000;
    localparam logic [23:0] CFG_VEC_HI = 24'hFF207F;
    localparam logic [23:0] HANDLER_VEC_LO = 24'hFF20C0;
    localparam logic [23:0] HANDLER_VEC_HI = 24'hFF21FF;
    localparam logic [23:0] PROG_LO = 24'hFF2000;
    localparam logic [23:0] PROG_HI = 24'hFF3FFF;
    // emulator hole in each overlay sub-range: low 20 bits F0000..F03FF
    localparam logic [19:0] OVL_EMU_LO = 20'hF0000;
    localparam logic [19:0] OVL_EMU_HI = 20'hF03FF;
    // local offsets into internal memories
    localparam int RAM_OFS_W = 12;
    localparam int ROM_OFS_W = 13;
    localparam int REGION_W = 4;

    // one code per region; one-hot select vector is indexed by this code
    typedef enum logic [3:0] {
        ASD_CPU_SFR = 4'h0,
        ASD_LOW_RF = 4'h1,
        ASD_UP_RF = 4'h2,
        ASD_CODE_RAM = 4'h3,
        ASD_PER_SFR = 4'h4,
        ASD_MM_SFR = 4'h5,
        ASD_ROM = 4'h6,
        ASD_EXTERNAL = 4'h7,
        ASD_EMU_RSVD = 4'h8,
        ASD_OVERLAY = 4'h9
    } asd_region_t;
    localparam int NUM_REGIONS = 10;

    // kind of program-memory area, reported beside the region
    typedef enum logic [1:0] {
        ASD_AREA_NONE = 2'h0,
        ASD_AREA_CFG_VEC = 2'h1,
        ASD_AREA_HANDLER_VEC = 2'h2,
        ASD_AREA_PROGRAM = 2'h3
    } asd_area_t;

    // addressing-mode permission bits
    localparam int MODE_W = 5;
    localparam int MODE_DIRECT = 0;
    localparam int MODE_WIN_DIRECT = 1;
    localparam int MODE_INDIRECT = 2;
    localparam int MODE_INDEXED = 3;
    localparam int MODE_EXTENDED = 4;
endpackage
`default_nettype wire

// ==== rtl/asd_decoder.sv ====
// asd_decoder: registered address classifier for the 24-bit cpu memory space.
// assumes the cpu presents one address with a valid strobe per cycle and samples
// the registered select outputs one cycle later.
`timescale 1ns/1ps
`default_nettype none
module asd_decoder #(
    parameter int ADDR_W = 24 // cpu address width
) (
    input wire logic clk, // cpu clock, 40 MHz
    input wire logic resetn, // synchronous reset, active low
    input wire logic addr_valid, // cpu presents an address this cycle
    input wire logic [ADDR_W-1:0] cpu_addr, // cpu address
    input wire logic external_program_select_pin, // high selects on-chip rom
    input wire logic rom_copy_disable_bit, // config bit: 1 routes low-page copy external
    output logic [ADDR_W-1:0] fetch_addr, // first fetch address after reset
    output logic decode_valid, // registered outputs hold a fresh decode
    output logic [asd_pkg::NUM_REGIONS-1:0] region_sel, // one-hot region select
    output logic [3:0] region_code, // encoded region
    output logic [1:0] area_kind, // program area kind
    output logic [asd_pkg::MODE_W-1:0] mode_allow, // allowed addressing modes
    output logic [asd_pkg::RAM_OFS_W-1:0] ram_offset, // code ram offset, shared by aliases
    output logic [asd_pkg::ROM_OFS_W-1:0] rom_offset, // rom offset
    output logic [ADDR_W-1:0] ext_addr // address driven onto the external bus
);

    // inclusive range test, used for every region except the overlay hole, which compares the low 20 bits directly
    function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // mode set builder
    function automatic logic [asd_pkg::MODE_W-1:0] modes(input logic d, input logic w,
                                                         input logic i, input logic x,
                                                         input logic e);
        modes = {e, x, i, w, d};
    endfunction

    // one-hot select bit for a region code; codes above the vector width select nothing
    function automatic logic [asd_pkg::NUM_REGIONS-1:0] region_onehot(input logic [3:0] code);
        region_onehot = '0;
        region_onehot[code] = 1'b1;
    endfunction

    // addressing-mode sets, bit order {extended, indexed, indirect, windowed, direct}
    localparam logic [asd_pkg::MODE_W-1:0] MODES_BUS = modes(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    localparam logic [asd_pkg::MODE_W-1:0] MODES_REG_LOW = modes(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    localparam logic [asd_pkg::MODE_W-1:0] MODES_REG_UP = modes(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    localparam logic [asd_pkg::MODE_W-1:0] MODES_PER_SFR = modes(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    localparam logic [asd_pkg::MODE_W-1:0] MODES_NONE = '0;

    // current address and what it decodes to
    logic [23:0] a;
    asd_pkg::asd_region_t region_next;
    asd_pkg::asd_area_t area_next;
    logic [asd_pkg::MODE_W-1:0] mode_next;
    logic prog_area;
    logic rom_sel;

    // one hit flag per range; region ranges are disjoint, the area ranges sit in program
    logic hit_cpu_sfr;
    logic hit_low_rf;
    logic hit_up_rf;
    logic hit_ram;
    logic hit_ram_alias;
    logic hit_per_sfr;
    logic hit_mm_sfr;
    logic hit_rom_copy;
    logic hit_overlay;
    logic hit_ovl_hole;
    logic hit_emu;
    logic hit_cfg_vec;
    logic hit_handler_vec;

    assign a = cpu_addr[23:0];
    // pin is sampled combinationally; it is a strap and stable in operation
    assign rom_sel = external_program_select_pin;
    assign prog_area = in_range(a, asd_pkg::PROG_LO, asd_pkg::PROG_HI);

    // page zero ranges
    assign hit_cpu_sfr = in_range(a, asd_pkg::CPU_SFR_LO, asd_pkg::CPU_SFR_HI);
    assign hit_low_rf = in_range(a, asd_pkg::LOW_RF_LO, asd_pkg::LOW_RF_HI);
    assign hit_up_rf = in_range(a, asd_pkg::UP_RF_LO, asd_pkg::UP_RF_HI);
    assign hit_ram = in_range(a, asd_pkg::RAM_LO, asd_pkg::RAM_HI);
    assign hit_per_sfr = in_range(a, asd_pkg::PER_SFR_LO, asd_pkg::PER_SFR_HI);
    assign hit_mm_sfr = in_range(a, asd_pkg::MM_SFR_LO, asd_pkg::MM_SFR_HI);
    assign hit_rom_copy = in_range(a, asd_pkg::ROM_COPY_LO, asd_pkg::ROM_COPY_HI);

    // middle span and top page ranges
    assign hit_overlay = in_range(a, asd_pkg::OVERLAY_LO, asd_pkg::OVERLAY_HI);
    // the hole test sees only the low 20 bits, so it repeats in every overlay sub-range
    assign hit_ovl_hole = (a[19:0] >= asd_pkg::OVL_EMU_LO) && (a[19:0] <= asd_pkg::OVL_EMU_HI);
    assign hit_emu = in_range(a, asd_pkg::EMU_LO, asd_pkg::EMU_HI);
    assign hit_ram_alias = in_range(a, asd_pkg::RAM_ALIAS_LO, asd_pkg::RAM_ALIAS_HI);
    // area ranges inside the program range; only read once the program range hits
    assign hit_cfg_vec = in_range(a, asd_pkg::CFG_VEC_LO, asd_pkg::CFG_VEC_HI);
    assign hit_handler_vec = in_range(a, asd_pkg::HANDLER_VEC_LO, asd_pkg::HANDLER_VEC_HI);

    // region classification; the if-chain gives each address exactly one region
    always_comb begin
        region_next = asd_pkg::ASD_EXTERNAL; // gaps default to the bus
        area_next = asd_pkg::ASD_AREA_NONE;
        mode_next = MODES_BUS;
        if (hit_cpu_sfr) begin
            region_next = asd_pkg::ASD_CPU_SFR;
            mode_next = MODES_REG_LOW;
        end else if (hit_low_rf) begin
            region_next = asd_pkg::ASD_LOW_RF;
            mode_next = MODES_REG_LOW;
        end else if (hit_up_rf) begin
            region_next = asd_pkg::ASD_UP_RF;
            mode_next = MODES_REG_UP;
        end else if (hit_ram || hit_ram_alias) begin
            // both aliases name one storage; the offset below drops the page
            region_next = asd_pkg::ASD_CODE_RAM;
        end else if (hit_per_sfr) begin
            region_next = asd_pkg::ASD_PER_SFR;
            mode_next = MODES_PER_SFR;
        end else if (hit_mm_sfr) begin
            region_next = asd_pkg::ASD_MM_SFR;
        end else if (hit_rom_copy) begin
            // copy is independent of the program pin: only the config bit steers it
            region_next = rom_copy_disable_bit ? asd_pkg::ASD_EXTERNAL
                                               : asd_pkg::ASD_ROM;
        end else if (hit_overlay && hit_ovl_hole) begin
            region_next = asd_pkg::ASD_EMU_RSVD;
            mode_next = MODES_NONE;
        end else if (hit_overlay) begin
            // reserved for future parts; decoded so no access falls through to the bus
            region_next = asd_pkg::ASD_OVERLAY;
        end else if (hit_emu) begin
            region_next = asd_pkg::ASD_EMU_RSVD;
            mode_next = MODES_NONE;
        end else if (prog_area) begin
            // rom or bus by the pin; the area kind is reported either way
            region_next = rom_sel ? asd_pkg::ASD_ROM : asd_pkg::ASD_EXTERNAL;
            if (hit_cfg_vec) begin
                area_next = asd_pkg::ASD_AREA_CFG_VEC;
            end else if (hit_handler_vec) begin
                area_next = asd_pkg::ASD_AREA_HANDLER_VEC;
            end else begin
                area_next = asd_pkg::ASD_AREA_PROGRAM;
            end
        end
    end

    // fetch start vector; constant after reset so the cpu can load its pc from it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fetch_addr <= asd_pkg::RESET_FETCH_ADDR;
        end
    end

    // decode strobe and select; nothing selected in a cycle without an address
    always_ff @(posedge clk) begin
        if (!resetn) begin
            decode_valid <= 1'b0;
            region_sel <= '0;
        end else begin
            decode_valid <= addr_valid;
            if (addr_valid) begin
                region_sel <= region_onehot(region_next);
            end else begin
                region_sel <= '0;
            end
        end
    end

    // region attributes hold between requests so a slow consumer can still read them
    always_ff @(posedge clk) begin
        if (!resetn) begin
            region_code <= 4'h0;
            area_kind <= 2'h0;
            mode_allow <= '0;
        end else if (addr_valid) begin
            region_code <= region_next;
            area_kind <= area_next;
            mode_allow <= mode_next;
        end
    end

    // offsets: both ram aliases drop the page, so they hit the same word
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ram_offset <= '0;
            rom_offset <= '0;
        end else if (addr_valid) begin
            ram_offset <= a[asd_pkg::RAM_OFS_W-1:0];
            rom_offset <= a[asd_pkg::ROM_OFS_W-1:0];
        end
    end

    // external bus address passed whole; the bus side picks its own chip select
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ext_addr <= '0;
        end else if (addr_valid) begin
            ext_addr <= cpu_addr;
        end
    end

endmodule // asd_decoder
`default_nettype wire

// ==== dv/asd_decoder_monitor.sv ====
// asd_decoder_monitor: map and timing checks on the decoder ports.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module asd_decoder_monitor #(
    parameter int ADDR_W = 24 // cpu address width
) (
    input wire logic clk, // cpu clock
    input wire logic resetn, // sync reset, active low
    input wire logic addr_valid, // request strobe
    input wire logic [ADDR_W-1:0] cpu_addr, // request address
    input wire logic external_program_select_pin, // rom when high
    input wire logic rom_copy_disable_bit, // copy window external when high
    input wire logic [ADDR_W-1:0] fetch_addr, // reset fetch address
    input wire logic decode_valid, // decode strobe
    input wire logic [asd_pkg::NUM_REGIONS-1:0] region_sel, // one-hot select
    input wire logic [3:0] region_code, // encoded region
    input wire logic [1:0] area_kind, // program area kind
    input wire logic [asd_pkg::MODE_W-1:0] mode_allow, // mode bits
    input wire logic [asd_pkg::RAM_OFS_W-1:0] ram_offset // code ram offset
);
    logic [ADDR_W-1:0] addr_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // last address, so a consequent one cycle on can still name it
    always_ff @(posedge clk) addr_reg <= cpu_addr;
    a_fetch_fixed: assert property (fetch_addr == 24'hFF2080)
        else $error("fetch address moved");
    a_sel_onehot: assert property (decode_valid |-> region_sel == (10'h001 << region_code))
        else $error("select not one-hot on code");
    a_idle_quiet: assert property (!decode_valid |-> region_sel == 10'h000)
        else $error("select high while idle");
    a_answer_next: assert property (addr_valid |=> decode_valid)
        else $error("no decode one cycle on");
    a_prog_route: assert property (addr_valid
        && cpu_addr inside {[24'hFF2000:24'hFF3FFF]}
        |=> region_code == ($past(external_program_select_pin) ? 4'h6 : 4'h7))
        else $error("program area misrouted");
    a_copy_route: assert property (addr_valid
        && cpu_addr inside {[24'h002400:24'h003FFF]}
        |=> region_code == ($past(rom_copy_disable_bit) ? 4'h7 : 4'h6))
        else $error("copy window misrouted");
    a_ram_alias: assert property (addr_valid && cpu_addr[11:10] != 2'h0
        && (cpu_addr[23:12] == 12'h000 || cpu_addr[23:12] == 12'hFF0)
        |=> region_code == 4'h3 && ram_offset == addr_reg[11:0])
        else $error("code ram alias wrong");
    a_mm_sfr: assert property (addr_valid
        && cpu_addr inside {[24'h001FE0:24'h001FFF]}
        |=> region_code == 4'h5 && mode_allow == 5'h1C)
        else $error("mm sfr decode wrong");
    a_per_sfr: assert property (addr_valid
        && cpu_addr inside {[24'h001C00:24'h001FDF]}
        |=> region_code == 4'h4 && mode_allow == 5'h1E)
        else $error("peripheral sfr decode wrong");
    a_emu_hole: assert property (addr_valid
        && cpu_addr inside {[24'hFF0000:24'hFF03FF]}
        |=> region_code == 4'h8 && mode_allow == 5'h00)
        else $error("emulator page decode wrong");
    a_ovl_hole: assert property (addr_valid
        && cpu_addr inside {[24'h1F0000:24'hFEFFFF]} && cpu_addr[19:10] == 10'h3C0
        |=> region_code == 4'h8 && mode_allow == 5'h00)
        else $error("overlay emulator hole wrong");
    a_cfg_area: assert property (addr_valid
        && cpu_addr inside {[24'hFF2000:24'hFF207F]}
        |=> area_kind == 2'h1)
        else $error("config area kind wrong");
    a_handler_area: assert property (addr_valid
        && cpu_addr inside {[24'hFF20C0:24'hFF21FF]}
        |=> area_kind == 2'h2)
        else $error("handler area kind wrong");
    c_rom: cover property (decode_valid && region_code == 4'h6);
    c_emu: cover property (decode_valid && region_code == 4'h8);
    c_ovl: cover property (decode_valid && region_code == 4'h9);
endmodule // asd_decoder_monitor
bind asd_decoder asd_decoder_monitor #(.ADDR_W(ADDR_W)) u_asd_decoder_monitor (
    .clk(clk), .resetn(resetn), .addr_valid(addr_valid), .cpu_addr(cpu_addr),
    .external_program_select_pin(external_program_select_pin),
    .rom_copy_disable_bit(rom_copy_disable_bit), .fetch_addr(fetch_addr),
    .decode_valid(decode_valid), .region_sel(region_sel), .region_code(region_code),
    .area_kind(area_kind), .mode_allow(mode_allow), .ram_offset(ram_offset)
);
`default_nettype wire

// ==== dv/asd_cpu_model.sv ====
// asd_cpu_model: cpu core side, issues one address per requested cycle.
// assumes the bench raises req at rising edges.
`timescale 1ns/1ps
`default_nettype none
module asd_cpu_model (
    input wire logic clk, // cpu clock
    input wire logic req, // bench wants an access
    input wire logic [23:0] req_addr, // address to issue
    output logic addr_valid, // strobe to decoder
    output logic [23:0] cpu_addr // address to decoder
);
    // idle cycles flip the address so a stale value never looks live
    always_ff @(posedge clk) begin
        addr_valid <= req;
        cpu_addr <= req ? req_addr : ~cpu_addr;
    end
endmodule // asd_cpu_model
`default_nettype wire

// ==== dv/asd_decoder_tb_top.sv ====
// asd_decoder_tb_top: corner and random address decode checks.
// assumes asd_pkg, the decoder and the cpu model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module asd_decoder_tb_top;
    logic clk = 0, resetn = 0, req = 0, pin = 1, cbit = 0, s_v, s_e, s_c, s_r;
    logic [23:0] req_addr = 0, s_a, cpu_addr, fetch_addr, ext_addr;
    logic addr_valid, decode_valid;
    logic [9:0] region_sel;
    logic [3:0] region_code, ec;
    logic [1:0] area_kind;
    logic [4:0] mode_allow;
    logic [11:0] ram_offset;
    logic [12:0] rom_offset;
    logic [31:0] r;
    int failures = 0, n_checks = 0, cyc = 0, seed = 14;
    logic [23:0] corners [22] = '{24'h000019, 24'h00001A, 24'h0000FF, 24'h000100,
        24'h0003FF, 24'h000400, 24'hFF0FFF, 24'h001C00, 24'h001FDF, 24'h001FE0,
        24'h001FFF, 24'h002400, 24'h003FFF, 24'h1F0000, 24'h2F03FF, 24'hFEFFFF,
        24'hFF0000, 24'hFF207F, 24'hFF20C0, 24'hFF21FF, 24'hFF3FFF, 24'h1EFFFF};
    always #12.5 clk = ~clk;
    asd_cpu_model u_asd_cpu_model (.clk(clk), .req(req), .req_addr(req_addr),
        .addr_valid(addr_valid), .cpu_addr(cpu_addr));
    asd_decoder u_asd_decoder (.clk(clk), .resetn(resetn), .addr_valid(addr_valid),
        .cpu_addr(cpu_addr), .external_program_select_pin(pin),
        .rom_copy_disable_bit(cbit), .fetch_addr(fetch_addr),
        .decode_valid(decode_valid), .region_sel(region_sel), .region_code(region_code),
        .area_kind(area_kind), .mode_allow(mode_allow), .ram_offset(ram_offset),
        .rom_offset(rom_offset), .ext_addr(ext_addr));
    function automatic logic [3:0] exp_code(logic [23:0] a, logic e, logic c);
        if (a <= 24'h000019) return 4'h0;
        if (a <= 24'h0000FF) return 4'h1;
        if (a <= 24'h0003FF) return 4'h2;
        if (a <= 24'h000FFF) return 4'h3;
        if (a >= 24'h001C00 && a <= 24'h001FDF) return 4'h4;
        if (a >= 24'h001FE0 && a <= 24'h001FFF) return 4'h5;
        if (a >= 24'h002400 && a <= 24'h003FFF) return c ? 4'h7 : 4'h6;
        if (a >= 24'h1F0000 && a <= 24'hFEFFFF) return a[19:10] == 10'h3C0 ? 4'h8 : 4'h9;
        if (a >= 24'hFF0000 && a <= 24'hFF03FF) return 4'h8;
        if (a >= 24'hFF0400 && a <= 24'hFF0FFF) return 4'h3;
        if (a >= 24'hFF2000 && a <= 24'hFF3FFF) return e ? 4'h6 : 4'h7;
        return 4'h7;
    endfunction
    function automatic logic [4:0] exp_mode(logic [3:0] c);
        if (c <= 4'h1) return 5'h0D;
        if (c == 4'h2) return 5'h0E;
        if (c == 4'h4) return 5'h1E;
        return c == 4'h8 ? 5'h00 : 5'h1C;
    endfunction
    function automatic logic [1:0] exp_area(logic [23:0] a);
        if (a >= 24'hFF2000 && a <= 24'hFF207F) return 2'h1;
        if (a >= 24'hFF20C0 && a <= 24'hFF21FF) return 2'h2;
        return (a >= 24'hFF2000 && a <= 24'hFF3FFF) ? 2'h3 : 2'h0;
    endfunction
    task automatic check(string what, logic [23:0] want, logic [23:0] got);
        n_checks++;
        if (got !== want) begin
            failures++;
            $display("Error %s expected %h seen %h", what, want, got);
        end
    endtask
    task automatic issue(logic v, logic [23:0] a, logic e, logic c);
        @(posedge clk);
        req <= v;
        req_addr <= a;
        pin <= e;
        cbit <= c;
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // what the decoder saw at the last edge, and a hang guard
    always @(posedge clk) begin
        {s_v, s_a, s_e, s_c, s_r} <= {addr_valid, cpu_addr, pin, cbit, resetn};
        cyc++;
        if (cyc == 10000) begin
            failures++;
            complete_run;
        end
    end
    // outputs have settled by the falling edge
    always @(negedge clk) begin
        if (s_r === 1'b0) begin
            check("reset_valid", 0, decode_valid);
            check("reset_sel", 0, region_sel);
            check("reset_fetch", 24'hFF2080, fetch_addr);
        end
        if (s_r === 1'b1) begin
            ec = exp_code(s_a, s_e, s_c);
            check("fetch", 24'hFF2080, fetch_addr);
            check("valid", s_v, decode_valid);
            check("sel", s_v ? 10'h001 << ec : 10'h000, region_sel);
            if (s_v === 1'b1) begin
                check("code", ec, region_code);
                check("mode", exp_mode(ec), mode_allow);
                check("area", exp_area(s_a), area_kind);
                check("ram_ofs", s_a[11:0], ram_offset);
                check("rom_ofs", s_a[12:0], rom_offset);
                check("ext", s_a, ext_addr);
                if (ec == 4'h8) check("rsvd_mode", 0, mode_allow);
            end
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        for (int m = 0; m < 4; m++) for (int i = 0; i < 22; i++) issue(1, corners[i], m[0], m[1]);
        $display("corner test done");
        issue(0, 0, 1, 0);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        $display("mid reset test done");
        repeat (3000) begin
            r = $random(seed);
            issue(r[0] | r[1], r[2] ? {{8{r[3]}}, r[23:8]} : r[31:8], r[4], r[5]);
        end
        issue(0, 0, 1, 0);
        repeat (2) @(posedge clk);
        $display("random test done");
        complete_run;
    end
endmodule // asd_decoder_tb_top
`default_nettype wire
